// ### rtl/modbus_status_regs.vh
// Constants for the status-read responder: frame fields, offsets and timing.
`ifndef MODBUS_STATUS_REGS_VH
`define MODBUS_STATUS_REGS_VH

// Function code for reading holding registers.
`define FUNC_READ_REGS 8'h03
// Register offsets served by this block.
`define REG_DEVICE_STATUS_TWO 16'h9006
`define REG_EXPANSION_DEVICE_STATUS 16'h9007
// Register count carried by an accepted query.
`define REG_COUNT_ONE 16'h0001
// Data byte count returned for one register.
`define BYTE_COUNT_ONE 8'h02
// Lowest and highest legal slave addresses.
`define SLAVE_ADDR_MIN 8'h01
`define SLAVE_ADDR_MAX 8'h10
// Address offset between axis number and slave address.
`define AXIS_ADDR_OFFSET 8'h01
// CRC-16 seed and reflected polynomial.
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
// Residue of a correct frame run through the CRC, check bytes included.
`define CRC_GOOD 16'h0000
// Query length in bytes and index of the last response byte.
`define QUERY_LEN 4'h8
`define RESP_LAST 3'h6
// Index of the first CRC byte in the response.
`define RESP_CRC_LO 3'h5
// Silent interval in microseconds and the clock period in nanoseconds.
`define SILENT_US 4000
`define MCLK_PERIOD_NS 8
`define NS_PER_US 1000

`endif

// ### rtl/crc16_step.v
// Running CRC-16 register fed one byte at a time.
`timescale 1ns/1ps
`include "modbus_status_regs.vh"

module crc16_step (
	// Clock and reset.
	input wire mclk,
	input wire rst,
	// Byte input; restart seeds the register before the byte is folded in.
	input wire restart,
	input wire enable,
	input wire [7:0] dataIn,
	// Current CRC value.
	output reg [15:0] crc
);

	wire [15:0] seed;
	wire [15:0] stage [0:8];

	// The seed is the init value at the start of a frame, else the running sum.
	assign seed = restart ? `CRC_INIT : crc;
	assign stage[0] = seed ^ {8'h00, dataIn};

	// One shift-and-xor stage per data bit.
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : bitStage
			assign stage[i + 1] = stage[i][0] ?
				((stage[i] >> 1) ^ `CRC_POLY) : (stage[i] >> 1);
		end
	endgenerate

	// The register folds in a byte whenever it is enabled.
	always @(posedge mclk) begin
		if (rst) begin
			crc <= `CRC_INIT;
		end else if (enable) begin
			crc <= stage[8];
		end
	end

endmodule

// ### rtl/modbus_status_read_slave.v
// Serial-line responder serving reads of the two device status words.
`timescale 1ns/1ps
`include "modbus_status_regs.vh"

module modbus_status_read_slave #(
	parameter SILENT_CYCLES = (`SILENT_US * `NS_PER_US + `MCLK_PERIOD_NS - 1)
		/ `MCLK_PERIOD_NS,
	parameter SILENT_W = 20
) (
	// Clock and reset.
	input wire mclk,
	input wire rst,
	// Axis identity.
	input wire [3:0] axisNumber,
	// Status words from the controller core.
	input wire [15:0] deviceStatusTwo,
	input wire [15:0] expansionDeviceStatus,
	// Received bytes from the serial receiver.
	input wire rxValid,
	input wire [7:0] rxByte,
	// Bytes to the serial transmitter.
	output reg txValid,
	output reg [7:0] txByte,
	input wire txReady,
	// Frame outcome pulses.
	output reg answered,
	output reg discarded
);

	localparam ST_RECV = 2'b00;
	localparam ST_SEND = 2'b01;
	localparam ST_HOLD = 2'b10;

	// Last count of the quiet timer, cut to the timer width on purpose.
	localparam integer SILENT_LAST_N = SILENT_CYCLES - 1;
	localparam [SILENT_W-1:0] SILENT_LAST = SILENT_LAST_N[SILENT_W-1:0];

	reg [1:0] state;
	reg [SILENT_W-1:0] silence;
	reg [3:0] rxCount;
	reg [63:0] frame;
	reg [7:0] ownAddr;
	reg [15:0] replyData;
	reg [2:0] txIndex;
	wire [15:0] rxCrc;
	wire [15:0] txCrc;
	wire rxTake;
	wire frameEnd;
	wire txLoad;
	wire [7:0] qAddr;
	wire [7:0] qFunc;
	wire [15:0] qStart;
	wire [15:0] qCount;
	wire addrOk;
	wire queryOk;

	// Picks the response byte for a given position.
	function [7:0] replyByte;
		input [2:0] idx;
		input [7:0] addr;
		input [15:0] data;
		input [15:0] crc;
		begin
			case (idx)
				3'h0: replyByte = addr;
				3'h1: replyByte = `FUNC_READ_REGS;
				3'h2: replyByte = `BYTE_COUNT_ONE;
				3'h3: replyByte = data[15:8];
				3'h4: replyByte = data[7:0];
				3'h5: replyByte = crc[7:0];
				default: replyByte = crc[15:8];
			endcase
		end
	endfunction

	// Bytes are taken only while listening; the line is half duplex.
	assign rxTake = rxValid && (state == ST_RECV);
	// A frame ends once the line has been quiet for a full interval.
	assign frameEnd = (state == ST_RECV) && !rxValid && (rxCount != 4'h0)
		&& (silence == SILENT_LAST);
	assign txLoad = (state == ST_SEND) && !txValid;

	// Query fields, first byte in the top of the shift register.
	assign qAddr = frame[63:56];
	assign qFunc = frame[55:48];
	assign qStart = frame[47:32];
	assign qCount = frame[31:16];
	assign addrOk = (qAddr == ownAddr) && (ownAddr >= `SLAVE_ADDR_MIN)
		&& (ownAddr <= `SLAVE_ADDR_MAX);
	assign queryOk = addrOk && (rxCount == `QUERY_LEN)
		&& (qFunc == `FUNC_READ_REGS) && (qCount == `REG_COUNT_ONE)
		&& ((qStart == `REG_DEVICE_STATUS_TWO)
		|| (qStart == `REG_EXPANSION_DEVICE_STATUS))
		&& (rxCrc == `CRC_GOOD);

	// Checks the received frame, check bytes included.
	crc16_step rxCheck (
		.mclk(mclk),
		.rst(rst),
		.restart(rxCount == 4'h0),
		.enable(rxTake),
		.dataIn(rxByte),
		.crc(rxCrc)
	);

	// Builds the check field of the response as its bytes are loaded.
	crc16_step txCheck (
		.mclk(mclk),
		.rst(rst),
		.restart(txIndex == 3'h0),
		.enable(txLoad && (txIndex < `RESP_CRC_LO)),
		.dataIn(replyByte(txIndex, ownAddr, replyData, txCrc)),
		.crc(txCrc)
	);

	// The own address follows the axis number.
	always @(posedge mclk) begin
		if (rst) begin
			ownAddr <= `AXIS_ADDR_OFFSET;
		end else begin
			ownAddr <= {4'h0, axisNumber} + `AXIS_ADDR_OFFSET;
		end
	end

	// Collects query bytes; counts saturate above a legal query length.
	always @(posedge mclk) begin
		if (rst) begin
			frame <= 64'h0;
			rxCount <= 4'h0;
		end else if (frameEnd) begin
			rxCount <= 4'h0;
		end else if (rxTake) begin
			frame <= {frame[55:0], rxByte};
			if (rxCount <= `QUERY_LEN) begin
				rxCount <= rxCount + 4'h1;
			end
		end
	end

	// Measures quiet time on the line; any traffic restarts it.
	always @(posedge mclk) begin
		if (rst) begin
			silence <= {SILENT_W{1'b0}};
		end else if (rxValid || (state == ST_SEND)) begin
			silence <= {SILENT_W{1'b0}};
		end else if (silence != SILENT_LAST) begin
			silence <= silence + {{(SILENT_W-1){1'b0}}, 1'b1};
		end
	end

	// Sequencer: listen, answer, then keep the line quiet before listening.
	always @(posedge mclk) begin
		if (rst) begin
			state <= ST_RECV;
			txValid <= 1'b0;
			txByte <= 8'h00;
			txIndex <= 3'h0;
			replyData <= 16'h0000;
			answered <= 1'b0;
			discarded <= 1'b0;
		end else begin
			answered <= 1'b0;
			discarded <= 1'b0;
			case (state)
				ST_RECV: begin
					txIndex <= 3'h0;
					if (frameEnd && queryOk) begin
						// The query's closing silence also leads the reply.
						state <= ST_SEND;
						if (qStart == `REG_DEVICE_STATUS_TWO) begin
							replyData <= deviceStatusTwo;
						end else begin
							replyData <= expansionDeviceStatus;
						end
					end else if (frameEnd) begin
						discarded <= 1'b1;
					end
				end
				ST_SEND: begin
					if (!txValid) begin
						txByte <= replyByte(txIndex, ownAddr, replyData,
							txCrc);
						txValid <= 1'b1;
					end else if (txReady) begin
						txValid <= 1'b0;
						txIndex <= txIndex + 3'h1;
						if (txIndex == `RESP_LAST) begin
							state <= ST_HOLD;
							answered <= 1'b1;
						end
					end
				end
				ST_HOLD: begin
					// Trailing silence; incoming bytes restart the wait.
					if (!rxValid && (silence == SILENT_LAST)) begin
						state <= ST_RECV;
					end
				end
				default: begin
					state <= ST_RECV;
				end
			endcase
		end
	end

endmodule

// ### tb/status_checker.sv
// Port-level checks for the status-read responder.
`timescale 1ns/1ps
module status_checker #(
	parameter SILENT_CYCLES = 20,
	parameter SILENT_W = 20
) (
	// Clock, reset and identity.
	input wire mclk,
	input wire rst,
	input wire [3:0] axisNumber,
	// Link signals.
	input wire rxValid,
	input wire txValid,
	input wire [7:0] txByte,
	input wire txReady,
	input wire answered,
	input wire discarded
);
	reg [2:0] txCnt;
	reg [SILENT_W-1:0] quiet;
	wire take = txValid && txReady;
	// Tracks the response byte position and the receive-side quiet time.
	always @(posedge mclk) begin
		if (rst || rxValid) quiet <= {SILENT_W{1'b0}};
		else if (~&quiet) quiet <= quiet + 1'b1;
		if (rst) txCnt <= 3'h0;
		else if (take) txCnt <= (txCnt == 3'h6) ? 3'h0 : txCnt + 3'h1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	hold_offer_a: assert property (txValid && !txReady |=>
		txValid && $stable(txByte)) else $error("offer changed");
	take_gap_a: assert property (take |=> !txValid)
		else $error("no gap after take");
	addr_echo_a: assert property (txValid && txCnt == 3'h0 |->
		txByte == {4'h0, axisNumber} + 8'h01) else $error("bad address");
	func_echo_a: assert property (txValid && txCnt == 3'h1 |->
		txByte == 8'h03) else $error("bad function");
	byte_count_a: assert property (txValid && txCnt == 3'h2 |->
		txByte == 8'h02) else $error("bad count");
	lead_quiet_a: assert property ($rose(txValid) && txCnt == 3'h0 |->
		quiet >= SILENT_CYCLES) else $error("reply too early");
	done_pulse_a: assert property (take && txCnt == 3'h6 |=>
		answered) else $error("no answered pulse");
	drop_silent_a: assert property (discarded |-> !txValid ##1
		!(txValid || discarded)) else $error("drop not silent");
endmodule

// ### tb/master_model.sv
// Serial master stand-in: sends query bytes and takes response bytes.
`timescale 1ns/1ps
module master_model (
	// Clock.
	input wire mclk,
	// Query bytes toward the responder.
	output reg rxValid,
	output reg [7:0] rxByte,
	// Response bytes from the responder.
	input wire txValid,
	input wire [7:0] txByte,
	output reg txReady
);
	logic [7:0] got[$];
	integer j;
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
		txReady = 1'b0;
	end
	// Takes offered bytes, stalling at random so slow takes occur too.
	always @(posedge mclk) begin
		if (txValid && txReady) got.push_back(txByte);
		txReady <= ($urandom % 3) != 0;
	end
	// Sends one frame back to back; the caller keeps the line quiet around it.
	task send(input logic [7:0] f[$]);
		begin
			got = {};
			for (j = 0; j < f.size(); j = j + 1) begin
				@(posedge mclk);
				rxValid <= 1'b1;
				rxByte <= f[j];
			end
			@(posedge mclk);
			rxValid <= 1'b0;
			rxByte <= ~f[f.size() - 1];
		end
	endtask
endmodule

// ### tb/modbus_status_read_slave_test.sv
// Self-checking bench for the status-read responder.
`timescale 1ns/1ps
module modbus_status_read_slave_test;
	localparam SIL = 20;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] axisNumber = 4'h0;
	reg [15:0] deviceStatusTwo = 16'h8000;
	reg [15:0] expansionDeviceStatus = 16'h33c7;
	wire rxValid, txValid, txReady, answered, discarded;
	wire [7:0] rxByte, txByte;
	integer n_errors = 0;
	integer num_checks = 0;
	integer i, k, n, sawAns, sawDrop;
	reg [31:0] rnd;
	reg [7:0] a;
	reg [15:0] c, word;
	logic [7:0] q[$];
	logic [7:0] expQ[$];
	modbus_status_read_slave #(.SILENT_CYCLES(SIL))
		modbus_status_read_slave_inst (.mclk(mclk), .rst(rst),
		.axisNumber(axisNumber), .deviceStatusTwo(deviceStatusTwo),
		.expansionDeviceStatus(expansionDeviceStatus), .rxValid(rxValid),
		.rxByte(rxByte), .txValid(txValid), .txByte(txByte),
		.txReady(txReady), .answered(answered), .discarded(discarded));
	master_model master_model_inst (.mclk(mclk), .rxValid(rxValid),
		.rxByte(rxByte), .txValid(txValid), .txByte(txByte),
		.txReady(txReady));
	initial forever #4 mclk = ~mclk;
	task check(input [15:0] seen, input [15:0] want);
		begin
			num_checks = num_checks + 1;
			if (seen !== want) begin
				n_errors = n_errors + 1;
				$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks=%0d errors=%0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	// Reflected CRC-16 over a byte queue, seeded with all ones.
	function [15:0] crcOf(input logic [7:0] f[$]);
		integer j, b;
		reg [15:0] r;
		begin
			r = 16'hffff;
			for (j = 0; j < f.size(); j = j + 1) begin
				r = r ^ {8'h00, f[j]};
				for (b = 0; b < 8; b = b + 1)
					r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
			end
			crcOf = r;
		end
	endfunction
	// Sends a query (mode 1 bad check, 2 short) and compares the model reply.
	task run(input [7:0] ad, input [7:0] fn, input [15:0] st,
		input [15:0] cn, input integer mode);
		begin
			q = {ad, fn, st[15:8], st[7:0], cn[15:8], cn[7:0]};
			c = crcOf(q);
			q.push_back(c[7:0] ^ {7'h00, mode == 1});
			if (mode != 2) q.push_back(c[15:8]);
			word = (st == 16'h9006) ? deviceStatusTwo : expansionDeviceStatus;
			expQ = {ad, 8'h03, 8'h02, word[15:8], word[7:0]};
			c = crcOf(expQ);
			expQ.push_back(c[7:0]);
			expQ.push_back(c[15:8]);
			k = ad == {4'h0, axisNumber} + 8'h01 && fn == 8'h03 && mode == 0
				&& cn == 16'h0001 && (st == 16'h9006 || st == 16'h9007);
			master_model_inst.send(q);
			sawAns = 0;
			sawDrop = 0;
			for (i = 0; i < 300 && !sawAns && !sawDrop; i = i + 1) begin
				@(negedge mclk);
				if (answered === 1'b1) sawAns = 1;
				if (discarded === 1'b1) sawDrop = 1;
			end
			check(sawAns, k);
			check(sawDrop, !k);
			for (i = 0; i < 7 && k; i = i + 1)
				check(master_model_inst.got[i], expQ[i]);
			repeat (SIL + 4) @(posedge mclk);
		end
	endtask
	initial begin
		rnd = $urandom(32'ha3e4);
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (SIL + 4) @(posedge mclk);
		run(8'h01, 8'h03, 16'h9006, 16'h0001, 0);
		check(master_model_inst.got[5], 8'hd9);
		run(8'h01, 8'h03, 16'h9007, 16'h0001, 0);
		check(master_model_inst.got[6], 8'h26);
		for (n = 0; n < 28; n = n + 1) begin
			rnd = $urandom;
			rst <= 1'b1;
			axisNumber <= rnd[3:0];
			deviceStatusTwo <= rnd[19:4];
			expansionDeviceStatus <= rnd[31:16];
			repeat (2) @(posedge mclk);
			rst <= 1'b0;
			repeat (SIL + 4) @(posedge mclk);
			a = {4'h0, axisNumber} + 8'h01;
			case (n % 7)
			0: run(a, 8'h03, 16'h9006, 16'h0001, 0);
			1: run(a, 8'h03, 16'h9007, 16'h0001, 0);
			2: run(a + 8'h01, 8'h03, 16'h9006, 16'h0001, 0);
			3: run(a, 8'h04, 16'h9006, 16'h0001, 0);
			4: run(a, 8'h03, 16'h9005, 16'h0001, 0);
			5: run(a, 8'h03, 16'h9007, 16'h0002, 0);
			default: run(a, 8'h03, 16'h9006, 16'h0001, 1 + n % 2);
			endcase
		end
		conclude;
	end
	// Cuts a hang short well past the expected run length.
	initial begin
		#200000;
		n_errors = n_errors + 1;
		conclude;
	end
endmodule
bind modbus_status_read_slave status_checker #(
	.SILENT_CYCLES(SILENT_CYCLES), .SILENT_W(SILENT_W)) status_checker_inst (
	.mclk(mclk), .rst(rst), .axisNumber(axisNumber), .rxValid(rxValid),
	.txValid(txValid), .txByte(txByte), .txReady(txReady),
	.answered(answered), .discarded(discarded));
